// ### rtc_pkg.sv
`default_nettype none

package rtc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_FIRST  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_SECONDS     = 4'h2;
  localparam logic [3:0] ADDR_MINUTES     = 4'h3;
  localparam logic [3:0] ADDR_HOURS       = 4'h4;
  localparam logic [3:0] ADDR_DATE        = 4'h5;
  localparam logic [3:0] ADDR_WEEKDAY     = 4'h6;
  localparam logic [3:0] ADDR_MONTH       = 4'h7;
  localparam logic [3:0] ADDR_YEAR        = 4'h8;
  localparam logic [3:0] ADDR_ALM_MINUTE  = 4'h9;
  localparam logic [3:0] ADDR_ALM_HOUR    = 4'hA;
  localparam logic [3:0] ADDR_ALM_DATE    = 4'hB;
  localparam logic [3:0] ADDR_ALM_WEEKDAY = 4'hC;
  localparam logic [3:0] ADDR_CLKOUT_CTRL = 4'hD;
  localparam logic [3:0] ADDR_TMR_CTRL    = 4'hE;
  localparam logic [3:0] ADDR_TMR_VALUE   = 4'hF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_TEST_MODE    = 7;  // test_mode_select_bit
  localparam int BIT_STOP         = 5;
  localparam int BIT_TEST_CTRL    = 3;  // test_control_bit
  localparam int BIT_OSC_HALT     = 0;  // oscillator_halt_bit
  localparam int BIT_ALARM_FLAG   = 3;
  localparam int BIT_TMR_FLAG     = 2;
  localparam int BIT_ALARM_IE     = 1;  // alarm_irq_enable
  localparam int BIT_TMR_IE       = 0;  // countdown_irq_enable
  localparam int BIT_CENTURY      = 7;
  localparam int BIT_ALM_DISABLE  = 7;
  localparam int BIT_ENABLE       = 7;
  localparam int ALARM_FIELDS     = 4;  // minute, hour, date, weekday

  // ----------------------------------------------------------------
  // values and reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_FIRST_RST = 8'h01;  // oscillator held halted
  localparam logic [7:0] DATE_RST       = 8'h01;
  localparam logic [7:0] MONTH_RST      = 8'h01;
  localparam logic [7:0] BCD_ZERO       = 8'h00;
  localparam logic [7:0] BCD_ONE        = 8'h01;
  localparam logic [7:0] MAX_SECMIN     = 8'h59;
  localparam logic [7:0] MAX_HOUR       = 8'h23;
  localparam logic [7:0] MAX_MONTH      = 8'h12;
  localparam logic [7:0] MAX_YEAR       = 8'h99;
  localparam logic [7:0] MAX_WEEKDAY    = 8'h06;
  localparam logic [7:0] MONTH_FEB      = 8'h02;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 25;

  typedef logic [15:0][7:0] reg_file_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    reg_file_t        regs;
    logic [7:0]       tmr_cnt;
    logic [DIV_W-1:0] div;
    logic [7:0]       rdata;
    logic             clk_out;
  } rtc_state_s;

endpackage

`default_nettype wire

// ### rtc_core.sv
// Summary of operation
// - time advances only while the oscillator halt bit is cleared.
// - after power-up reset the oscillator halt bit is set, so counting is held.
// - test mode bit zero selects normal mode; writing zero to register zero runs.
// - stop bit zero clocks time from the second source; set holds counting.
// - test control bit zero gives normal pacing, no accelerated test ticks.
// - alarm enable bit zero keeps alarm matches off the interrupt output.
// - timer enable bit zero keeps countdown events off the interrupt output.
// - month bit 7 is century flag, 1 for 19xx, 0 for 20xx.
`timescale 1ns/1ps
`default_nettype none

module rtc_core
  import rtc_pkg::*;
#(
  parameter int CYCLES_PER_SECOND = SECOND_CYCLES
) (
  input  wire logic     clk,       // 25 MHz system clock
  input  wire logic     reset_n,   // async reset, active low
  input  wire reg_req_s reg_req,   // register access request
  output logic    [7:0] reg_rdata, // read data, one cycle after rd
  output logic          irq_n,     // interrupt, active low
  output logic          clk_out    // programmable square wave
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_SECOND - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CYCLES_PER_SECOND / 2);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = v[7:4];
    lo = v[3:0];
    if (lo == 4'h9) begin
      hi = hi + 4'h1;
      lo = 4'h0;
    end else begin
      lo = lo + 4'h1;
    end
    return {hi, lo};
  endfunction

  function automatic logic [6:0] bcd_to_bin(input logic [7:0] v);
    return 7'(v[7:4]) * 7'h0A + 7'(v[3:0]);
  endfunction

  function automatic logic [7:0] month_last_day(input logic [7:0] mon, input logic [7:0] yr);
    logic [6:0] y;
    y = bcd_to_bin(yr);
    unique case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      MONTH_FEB:                  return (y[1:0] == 2'h0) ? 8'h29 : 8'h28;
      default:                    return 8'h31;
    endcase
  endfunction

  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lim);
    return (v[3:0] <= 4'h9) && (v <= lim);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtc_state_s state_ff;
  rtc_state_s nxt_state;
  logic       run;
  logic       sec_tick;
  logic       day_wrap;
  logic       year_wrap;
  logic       alarm_hit;
  logic       tmr_hit;

  always_comb begin
    logic [7:0] c1;
    logic [7:0] mon;
    logic [7:0] mon_inc;
    logic       alm_any;
    logic       alm_match;
    nxt_state = state_ff;
    c1        = state_ff.regs[ADDR_CTRL_FIRST];
    sec_tick  = 1'b0;
    day_wrap  = 1'b0;
    year_wrap = 1'b0;
    alarm_hit = 1'b0;
    tmr_hit   = 1'b0;
    alm_any   = 1'b0;
    alm_match = 1'b1;
    mon       = {3'h0, state_ff.regs[ADDR_MONTH][4:0]};
    mon_inc   = bcd_inc(mon);

    // halt gates counting; test mode holds it; stop holds it
    run = !c1[BIT_OSC_HALT] && !c1[BIT_TEST_MODE] && !c1[BIT_STOP];

    if (!run) begin
      nxt_state.div = '0;
    end else if (c1[BIT_TEST_CTRL] || state_ff.div == DIV_LAST) begin
      nxt_state.div = '0;
      sec_tick      = 1'b1;
    end else begin
      nxt_state.div = state_ff.div + DIV_W'(1);
    end

    if (sec_tick) begin
      if (state_ff.regs[ADDR_SECONDS][6:0] != MAX_SECMIN[6:0]) begin
        nxt_state.regs[ADDR_SECONDS] = bcd_inc({1'b0, state_ff.regs[ADDR_SECONDS][6:0]});
      end else begin
        nxt_state.regs[ADDR_SECONDS] = BCD_ZERO;
        if (state_ff.regs[ADDR_MINUTES][6:0] != MAX_SECMIN[6:0]) begin
          nxt_state.regs[ADDR_MINUTES] = bcd_inc({1'b0, state_ff.regs[ADDR_MINUTES][6:0]});
        end else begin
          nxt_state.regs[ADDR_MINUTES] = BCD_ZERO;
          if (state_ff.regs[ADDR_HOURS][5:0] != MAX_HOUR[5:0]) begin
            nxt_state.regs[ADDR_HOURS] = bcd_inc({2'h0, state_ff.regs[ADDR_HOURS][5:0]});
          end else begin
            nxt_state.regs[ADDR_HOURS] = BCD_ZERO;
            day_wrap = 1'b1;
          end
        end
      end
    end

    if (day_wrap) begin
      if (state_ff.regs[ADDR_WEEKDAY][2:0] >= MAX_WEEKDAY[2:0]) begin
        nxt_state.regs[ADDR_WEEKDAY] = BCD_ZERO;
      end else begin
        nxt_state.regs[ADDR_WEEKDAY] = {5'h0, state_ff.regs[ADDR_WEEKDAY][2:0] + 3'h1};
      end
      if (state_ff.regs[ADDR_DATE][5:0]
          != month_last_day(mon, state_ff.regs[ADDR_YEAR])) begin
        nxt_state.regs[ADDR_DATE] = bcd_inc({2'h0, state_ff.regs[ADDR_DATE][5:0]});
      end else begin
        nxt_state.regs[ADDR_DATE] = BCD_ONE;
        if (mon != MAX_MONTH) begin
          nxt_state.regs[ADDR_MONTH][4:0] = mon_inc[4:0];
        end else begin
          nxt_state.regs[ADDR_MONTH][4:0] = BCD_ONE[4:0];
          if (state_ff.regs[ADDR_YEAR] != MAX_YEAR) begin
            nxt_state.regs[ADDR_YEAR] = bcd_inc(state_ff.regs[ADDR_YEAR]);
          end else begin
            nxt_state.regs[ADDR_YEAR] = BCD_ZERO;
            year_wrap = 1'b1;
            // century flag flips at the year wrap
            nxt_state.regs[ADDR_MONTH][BIT_CENTURY] = !state_ff.regs[ADDR_MONTH][BIT_CENTURY];
          end
        end
      end
    end

    // alarm compares after the day rollover, so date and weekday are the new ones
    for (int i = 0; i < ALARM_FIELDS; i++) begin
      if (!state_ff.regs[ADDR_ALM_MINUTE + 4'(i)][BIT_ALM_DISABLE]) begin
        alm_any = 1'b1;
        if (nxt_state.regs[ADDR_MINUTES + 4'(i)][6:0]
            != state_ff.regs[ADDR_ALM_MINUTE + 4'(i)][6:0]) begin
          alm_match = 1'b0;
        end
      end
    end
    alarm_hit = sec_tick && alm_any && alm_match
                && state_ff.regs[ADDR_SECONDS][6:0] == MAX_SECMIN[6:0];

    // countdown, paced by the same seconds tick
    if (sec_tick && state_ff.regs[ADDR_TMR_CTRL][BIT_ENABLE]) begin
      if (state_ff.tmr_cnt <= BCD_ONE) begin
        tmr_hit           = 1'b1;
        nxt_state.tmr_cnt = state_ff.regs[ADDR_TMR_VALUE];
      end else begin
        nxt_state.tmr_cnt = state_ff.tmr_cnt - 8'h01;
      end
    end

    // host write wins over the counting chain for the same register
    if (reg_req.wr) begin
      nxt_state.regs[reg_req.addr] = reg_req.wdata;
      if (reg_req.addr == ADDR_SECONDS) begin
        nxt_state.div = '0;
      end
      if (reg_req.addr == ADDR_TMR_VALUE) begin
        nxt_state.tmr_cnt = reg_req.wdata;
      end
      if (reg_req.addr == ADDR_CTRL_SECOND) begin
        // flags clear only where written zero
        nxt_state.regs[ADDR_CTRL_SECOND][BIT_ALARM_FLAG] =
          state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_FLAG] && reg_req.wdata[BIT_ALARM_FLAG];
        nxt_state.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG] =
          state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG] && reg_req.wdata[BIT_TMR_FLAG];
      end
    end
    // an event in the clearing cycle is kept
    if (alarm_hit) begin
      nxt_state.regs[ADDR_CTRL_SECOND][BIT_ALARM_FLAG] = 1'b1;
    end
    if (tmr_hit) begin
      nxt_state.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG] = 1'b1;
    end

    if (reg_req.rd) begin
      nxt_state.rdata = state_ff.regs[reg_req.addr];
    end
    nxt_state.clk_out = run && state_ff.regs[ADDR_CLKOUT_CTRL][BIT_ENABLE] && state_ff.div < DIV_HALF;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff                        <= '0;
      state_ff.regs[ADDR_CTRL_FIRST]  <= CTRL_FIRST_RST;
      state_ff.regs[ADDR_DATE]        <= DATE_RST;
      state_ff.regs[ADDR_MONTH]       <= MONTH_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign clk_out   = state_ff.clk_out;
  // each source gated by its enable
  assign irq_n     = !((state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_FLAG]
                        && state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_IE])
                       || (state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG]
                        && state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_IE]));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic first_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_quiet;
    !reg_req.wr && !run;
  endsequence

  sequence s_no_tick_after;
    (!sec_tick || state_ff.regs[ADDR_CTRL_FIRST][BIT_TEST_CTRL]) [*8];
  endsequence

  property p_halt_holds_time;
    (s_quiet and state_ff.regs[ADDR_CTRL_FIRST][BIT_OSC_HALT])
      |=> $stable(state_ff.regs[ADDR_SECONDS]) && $stable(state_ff.regs[ADDR_MINUTES]);
  endproperty
  a_halt_holds_time: assert property (p_halt_holds_time) else $error("time moved while halted");

  property p_powerup_halted;
    first_ff |-> state_ff.regs[ADDR_CTRL_FIRST][BIT_OSC_HALT] && !sec_tick;
  endproperty
  a_powerup_halted: assert property (p_powerup_halted) else $error("oscillator ran after reset");

  property p_test_mode_no_tick;
    state_ff.regs[ADDR_CTRL_FIRST][BIT_TEST_MODE] |-> !sec_tick ##1 state_ff.div == '0;
  endproperty
  a_test_mode_no_tick: assert property (p_test_mode_no_tick) else $error("tick in test mode");

  property p_stop_no_tick;
    state_ff.regs[ADDR_CTRL_FIRST][BIT_STOP] && !reg_req.wr
      |=> !sec_tick && $stable(state_ff.regs[ADDR_SECONDS]);
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick) else $error("counting while stopped");

  property p_normal_pacing;
    sec_tick && !state_ff.regs[ADDR_CTRL_FIRST][BIT_TEST_CTRL] |=> s_no_tick_after;
  endproperty
  a_normal_pacing: assert property (p_normal_pacing) else $error("ticks too close");

  property p_alarm_masked;
    !state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_IE]
      && !(state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG] && state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_IE])
      |-> irq_n;
  endproperty
  a_alarm_masked: assert property (p_alarm_masked) else $error("alarm reached irq while disabled");

  property p_timer_masked;
    !state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_IE] && tmr_hit
      && !((state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_FLAG] || alarm_hit)
           && state_ff.regs[ADDR_CTRL_SECOND][BIT_ALARM_IE])
      && !reg_req.wr |=> irq_n && state_ff.regs[ADDR_CTRL_SECOND][BIT_TMR_FLAG];
  endproperty
  a_timer_masked: assert property (p_timer_masked) else $error("timer reached irq while disabled");

  property p_century_flip;
    year_wrap && !reg_req.wr |=> state_ff.regs[ADDR_YEAR] == BCD_ZERO
      && state_ff.regs[ADDR_MONTH][BIT_CENTURY] != $past(state_ff.regs[ADDR_MONTH][BIT_CENTURY]);
  endproperty
  a_century_flip: assert property (p_century_flip) else $error("century flag not flipped");

  property p_bcd_seconds;
    sec_tick && !reg_req.wr && bcd_ok(state_ff.regs[ADDR_SECONDS], MAX_SECMIN)
      |=> bcd_ok(state_ff.regs[ADDR_SECONDS], MAX_SECMIN) && bcd_ok(state_ff.regs[ADDR_MINUTES], MAX_SECMIN);
  endproperty
  a_bcd_seconds: assert property (p_bcd_seconds) else $error("seconds left BCD range");

  property p_weekday_step;
    day_wrap && !reg_req.wr && state_ff.regs[ADDR_WEEKDAY] <= MAX_WEEKDAY
      |=> state_ff.regs[ADDR_WEEKDAY] == (($past(state_ff.regs[ADDR_WEEKDAY]) == MAX_WEEKDAY)
          ? BCD_ZERO : $past(state_ff.regs[ADDR_WEEKDAY]) + 8'h01);
  endproperty
  a_weekday_step: assert property (p_weekday_step) else $error("weekday did not step");

endmodule

`default_nettype wire

// ### rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model
  import rtc_pkg::*;
(
  input  wire logic       clk,       // register port clock
  output var  reg_req_s   reg_req,   // request towards the device
  input  wire logic [7:0] reg_rdata  // read data from the device
);
  initial begin
    reg_req = '0;
  end

  // ----------------------------------------------------------------
  // port release
  // ----------------------------------------------------------------
  // released fields show inverted last values so nothing stale can match
  task automatic release_port();
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  // ----------------------------------------------------------------
  // accesses
  // ----------------------------------------------------------------
  // host loads registers
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_req.wr    = 1'b1;
    reg_req.addr  = addr;
    reg_req.wdata = data;
    @(negedge clk);
    release_port();
  endtask

  // data is valid just after the edge that takes rd and is read at the next falling edge
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_req.rd   = 1'b1;
    reg_req.addr = addr;
    @(negedge clk);
    data = reg_rdata;
    release_port();
  endtask
endmodule

`default_nettype wire

// ### rtc_control_register_map_bench.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_control_register_map_bench
  import rtc_pkg::*;
;
  localparam int CPS = 16;
  localparam logic [7:0] ROLL_EXP [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00};
  localparam logic [3:0] LD_ADDR [0:14] = '{ADDR_CTRL_FIRST, ADDR_ALM_MINUTE, ADDR_ALM_HOUR,
    ADDR_ALM_DATE, ADDR_ALM_WEEKDAY, ADDR_TMR_VALUE, ADDR_TMR_CTRL, ADDR_CTRL_SECOND, ADDR_MINUTES,
    ADDR_HOURS, ADDR_DATE, ADDR_WEEKDAY, ADDR_MONTH, ADDR_YEAR, ADDR_SECONDS};
  localparam logic [7:0] LD_DATA [0:14] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h01, 8'h80, 8'h00,
    8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99, 8'h58};
  localparam logic [7:0] HOLD_MODE [0:2] = '{8'h20, 8'h80, 8'h01};
  localparam logic [7:0] IRQ_WR [0:3] = '{8'h0E, 8'h06, 8'h05, 8'h01};
  localparam logic       IRQ_EXP [0:3] = '{1'b0, 1'b1, 1'b0, 1'b1};

  logic       clk;
  logic       reset_n;
  reg_req_s   reg_req;
  logic [7:0] reg_rdata;
  logic       irq_n;
  logic       clk_out;
  int         n_errors;
  int         total_checks;
  int         cycles = 0;
  logic [7:0] seen;
  logic [7:0] held;

  rtc_core #(
    .CYCLES_PER_SECOND (CPS)
  ) i_dut (
    .clk       (clk),
    .reset_n   (reset_n),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .irq_n     (irq_n),
    .clk_out   (clk_out)
  );

  rtc_host_model i_host (
    .clk       (clk),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata)
  );

  initial begin
    clk = 1'b0;
  end

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected 0x%h seen 0x%h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, main sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors     = 0;
    total_checks = 0;
    reset_n      = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    check_bit("irq_n reset", 1'b1, irq_n);
    check_bit("clk_out reset", 1'b0, clk_out);
    for (int a = 0; a < 16; a++) begin
      i_host.read_reg(a[3:0], seen);
      check_byte("reset value", (a == 0 || a == 5 || a == 7) ? 8'h01 : 8'h00, seen);
    end
    repeat (3 * CPS) @(negedge clk);
    i_host.read_reg(ADDR_SECONDS, seen);
    check_byte("seconds while halted", 8'h00, seen);
    // enable first, load the time last so the divider restarts
    for (int i = 0; i < 15; i++) begin
      i_host.write_reg(LD_ADDR[i], LD_DATA[i]);
    end
    // two ticks: 58 to 59, then the full year rollover
    repeat (2 * CPS + 4) @(negedge clk);
    i_host.write_reg(ADDR_CTRL_FIRST, 8'h20);
    for (int a = 2; a < 9; a++) begin
      i_host.read_reg(a[3:0], seen);
      check_byte("rollover", ROLL_EXP[a-2], seen);
    end
    i_host.read_reg(ADDR_CTRL_SECOND, seen);
    check_byte("flags with enables off", 8'h0C, seen);
    check_bit("irq_n masked", 1'b1, irq_n);
    check_bit("clk_out stopped", 1'b0, clk_out);
    // each enable gates only its own flag
    for (int i = 0; i < 4; i++) begin
      i_host.write_reg(ADDR_CTRL_SECOND, IRQ_WR[i]);
      check_bit("irq_n gating", IRQ_EXP[i], irq_n);
    end
    i_host.read_reg(ADDR_CTRL_SECOND, seen);
    check_byte("flags cleared", 8'h01, seen);
    i_host.read_reg(ADDR_SECONDS, held);
    // stop, test mode and halt each hold the count
    for (int i = 0; i < 3; i++) begin
      i_host.write_reg(ADDR_CTRL_FIRST, HOLD_MODE[i]);
      repeat (3 * CPS) @(negedge clk);
      i_host.read_reg(ADDR_SECONDS, seen);
      check_byte("seconds held", held, seen);
    end
    // test control runs one tick per clock: two edges before the halt lands
    i_host.write_reg(ADDR_CTRL_FIRST, 8'h08);
    i_host.write_reg(ADDR_CTRL_FIRST, 8'h01);
    i_host.read_reg(ADDR_SECONDS, seen);
    check_byte("fast ticks", 8'h02, seen);
    check_bit("irq_n timer enabled", 1'b0, irq_n);
    // square wave high for the first half second after run rises
    i_host.write_reg(ADDR_CLKOUT_CTRL, 8'h80);
    i_host.write_reg(ADDR_CTRL_FIRST, 8'h00);
    @(negedge clk);
    check_bit("clk_out first half", 1'b1, clk_out);
    repeat (CPS / 2) @(negedge clk);
    check_bit("clk_out second half", 1'b0, clk_out);
    // second reset in mid-run
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check_bit("irq_n second reset", 1'b1, irq_n);
    check_bit("clk_out second reset", 1'b0, clk_out);
    i_host.read_reg(ADDR_CTRL_FIRST, seen);
    check_byte("halt after reset", 8'h01, seen);
    i_host.read_reg(ADDR_MONTH, seen);
    check_byte("month after reset", 8'h01, seen);
    tally_and_finish();
  end
endmodule

`default_nettype wire
